// >>> hw/tcce_regs.svh
// register map, field positions and reset values of the timer control block
`ifndef TCCE_REGS_SVH
`define TCCE_REGS_SVH

// ----------------------------------------------------------------
// byte offsets on the apb bus
// ----------------------------------------------------------------
`define TCCE_OFF_CTRL 8'h00
`define TCCE_OFF_CNT_LO 8'h04
`define TCCE_OFF_CNT_UP 8'h08
`define TCCE_OFF_PRD_LO 8'h0c
`define TCCE_OFF_PRD_UP 8'h10
`define TCCE_OFF_REL_LO 8'h14
`define TCCE_OFF_REL_UP 8'h18
`define TCCE_OFF_CFG 8'h1c
`define TCCE_OFF_STAT 8'h20
`define TCCE_OFF_MASK 8'h24

// ----------------------------------------------------------------
// control fields, offsets from each half's base bit
// ----------------------------------------------------------------
`define TCCE_LO_BASE 6
`define TCCE_UP_BASE 22
`define TCCE_F_MODE 0
`define TCCE_F_SRC 2
`define TCCE_F_RDCLR 4
`define TCCE_F_CAPEN 5
`define TCCE_F_EDGE 6
`define TCCE_CTRL_WMASK 32'h0dc0_3dc0

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define TCCE_CFG_UNCH 0
`define TCCE_CFG_EDGE 4
`define TCCE_CFG_WMASK 32'h0000_0031

// ----------------------------------------------------------------
// reset values and status layout
// ----------------------------------------------------------------
`define TCCE_CTRL_RST 32'h0000_0000
`define TCCE_CFG_RST 32'h0000_0001
`define TCCE_CNT_RST 32'h0000_0000
`define TCCE_PRD_RST 32'hffff_ffff
`define TCCE_STAT_W 4
`define TCCE_ST_CAP 2

`endif

// >>> hw/tcce_pkg.sv
// types shared by the timer control block
`default_nettype none
package tcce_pkg;
  // counter enabling modes
  typedef enum logic [1:0] {
    TCCE_RUN_OFF = 2'b00,
    TCCE_RUN_ONCE = 2'b01,
    TCCE_RUN_CONT = 2'b10,
    TCCE_RUN_RELOAD = 2'b11
  } tcce_run_mode_t;
  // capture edge selection
  typedef enum logic [1:0] {
    TCCE_EDGE_RISE = 2'b00,
    TCCE_EDGE_FALL = 2'b01,
    TCCE_EDGE_BOTH = 2'b10,
    TCCE_EDGE_NONE = 2'b11
  } tcce_edge_t;
endpackage
`default_nettype wire

// >>> hw/tcce_half.sv
// one 32-bit counter half: run modes, capture, read clear, reload
`include "tcce_regs.svh"
`default_nettype none
module tcce_half #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controls
  input wire tcce_pkg::tcce_run_mode_t run_mode,
  input wire logic count_source_select,
  input wire logic read_clears_count,
  input wire logic capture_enable,
  input wire tcce_pkg::tcce_edge_t capture_edge_select,
  input wire logic unchained,
  // synchronised timer input, now and one cycle earlier
  input wire logic in_now,
  input wire logic in_prev,
  // software accesses
  input wire logic count_read,
  input wire logic wr_count,
  input wire logic wr_period,
  input wire logic wr_reload,
  input wire logic [WIDTH-1:0] wdata,
  // state and events
  output logic [WIDTH-1:0] count_value,
  output logic [WIDTH-1:0] period_value,
  output logic [WIDTH-1:0] period_reload_value,
  output logic period_event,
  output logic capture_event
);
  logic rise, fall, tick, edge_hit, cap_ok, cap_evt, rd_clr;
  logic hit, running, wrap, once_hit;
  logic [WIDTH-1:0] count_inc, next_count, next_period;

  // input edges; external clock counts on rising edges
  assign rise = in_now & ~in_prev;
  assign fall = ~in_now & in_prev;
  // R08: count source
  assign tick = count_source_select ? rise : 1'b1;

  // R01: edge choice; R17: reserved code never fires
  assign edge_hit = (capture_edge_select == tcce_pkg::TCCE_EDGE_RISE) ? rise :
                    (capture_edge_select == tcce_pkg::TCCE_EDGE_FALL) ? fall :
                    (capture_edge_select == tcce_pkg::TCCE_EDGE_BOTH) ? (rise | fall) :
                    1'b0;
  // R02: capture only when unchained, internal, continuous or reload
  assign cap_ok = capture_enable & unchained & ~count_source_select & run_mode[1];
  // R03: selected edge resets counter
  assign cap_evt = cap_ok & edge_hit;
  // R05: read clears; R06: unchained only
  assign rd_clr = read_clears_count & unchained & count_read;

  // R09: off holds; R10: once stops at period
  assign hit = (count_value == period_value);
  assign running = (run_mode != tcce_pkg::TCCE_RUN_OFF) &&
                   !(run_mode == tcce_pkg::TCCE_RUN_ONCE && hit);
  // R11: wrap to zero the tick after matching
  assign wrap = tick & run_mode[1] & hit;
  assign count_inc = count_value + 1'b1;
  assign once_hit = tick & (run_mode == tcce_pkg::TCCE_RUN_ONCE) & ~hit &
                    (count_inc == period_value);

  // software write beats read clear and capture, which both zero the count and beat counting
  assign next_count = wr_count ? wdata :
                      (rd_clr | cap_evt) ? '0 :
                      (running & tick) ? (wrap ? '0 : count_inc) :
                      count_value;
  // R12: period reloaded on each wrap in reload mode
  assign next_period = wr_period ? wdata :
                       (wrap && run_mode == tcce_pkg::TCCE_RUN_RELOAD) ?
                       period_reload_value : period_value;

  // counter state; R07: read clear raises no event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= `TCCE_CNT_RST;
      period_value <= `TCCE_PRD_RST;
      period_reload_value <= `TCCE_PRD_RST;
      period_event <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      count_value <= next_count;
      period_value <= next_period;
      if (wr_reload) begin
        period_reload_value <= wdata;
      end
      period_event <= (wrap | once_hit) & ~wr_count;
      capture_event <= cap_evt & ~wr_count;
    end
  end
endmodule
`default_nettype wire

// >>> hw/tcce_top.sv
// dual 32-bit timer control with apb registers and capture inputs
//
// Notes on behaviour
// R01: upper edge select: rise, fall, both, reserved
// R02: capture needs unchained, internal, continuous mode; the code also captures in reload mode
// R03: capture enable lets input edge reset counter
// R04: each capture raises the output events
// R05: read-clear mode resets counter on read
// R06: read clear works only when unchained
// R07: read clear raises no events
// R08: source bit picks internal or input clock
// R09: mode zero holds the count
// R10: one-shot stops when count reaches period
// R11: continuous wraps to zero after matching
// R12: reload mode copies reload into period
// R13: lower edge select at bits 13-12
// R14: control bits 29-28, 21-14 read zero
// R15: lower half control bit positions
// R16: period and count registers, 32 bits
// R17: reserved writes ignored, edge code 3 silent
//
// The address map and the APB slave port were left to the implementer.
`include "tcce_regs.svh"
`default_nettype none
module tcce_top #(
  parameter int WIDTH = 32,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer input pins, bit 0 lower half, bit 1 upper half
  input wire logic [1:0] timer_in,
  // events
  output logic [1:0] event_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] timer_control;
  logic [31:0] timer_config;
  logic [`TCCE_STAT_W-1:0] irq_status;
  logic [`TCCE_STAT_W-1:0] irq_mask;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_rd, acc_wr, acc_rd;
  logic sel_ctrl, sel_cfg, sel_stat, sel_mask;
  logic sel_cnt_lo, sel_cnt_up, sel_prd_lo, sel_prd_up;
  logic sel_rel_lo, sel_rel_up, mapped;

  // each access phase completes in its first cycle
  assign pready = 1'b1;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;

  // address decode, unaligned offsets fall through to unmapped
  assign sel_ctrl = (paddr == `TCCE_OFF_CTRL);
  assign sel_cnt_lo = (paddr == `TCCE_OFF_CNT_LO);
  assign sel_cnt_up = (paddr == `TCCE_OFF_CNT_UP);
  assign sel_prd_lo = (paddr == `TCCE_OFF_PRD_LO);
  assign sel_prd_up = (paddr == `TCCE_OFF_PRD_UP);
  assign sel_rel_lo = (paddr == `TCCE_OFF_REL_LO);
  assign sel_rel_up = (paddr == `TCCE_OFF_REL_UP);
  assign sel_cfg = (paddr == `TCCE_OFF_CFG);
  assign sel_stat = (paddr == `TCCE_OFF_STAT);
  assign sel_mask = (paddr == `TCCE_OFF_MASK);
  assign mapped = sel_ctrl | sel_cnt_lo | sel_cnt_up | sel_prd_lo |
                  sel_prd_up | sel_rel_lo | sel_rel_up | sel_cfg |
                  sel_stat | sel_mask;

  // unmapped accesses answer with an error and change nothing
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // input synchronisers and edge history
  // ----------------------------------------------------------------
  logic [1:0] in_meta;
  logic [1:0] in_sync;
  logic [1:0] in_prev;

  // pin is async: two flops, then a history flop for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 2'h0;
      in_sync <= 2'h0;
      in_prev <= 2'h0;
    end else begin
      in_meta <= timer_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  // ----------------------------------------------------------------
  // per-half field extraction and counters
  // ----------------------------------------------------------------
  logic [1:0][WIDTH-1:0] cnt;
  logic [1:0][WIDTH-1:0] prd;
  logic [1:0][WIDTH-1:0] rel;
  logic [1:0] per_evt;
  logic [1:0] cap_evt;
  logic [1:0] sel_cnt;
  logic [1:0] sel_prd;
  logic [1:0] sel_rel;
  logic unchained;

  assign sel_cnt = {sel_cnt_up, sel_cnt_lo};
  assign sel_prd = {sel_prd_up, sel_prd_lo};
  assign sel_rel = {sel_rel_up, sel_rel_lo};
  // unchained bit only gates capture and read clear; the halves always count independently
  assign unchained = timer_config[`TCCE_CFG_UNCH];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      localparam int BASE = (g == 0) ? `TCCE_LO_BASE : `TCCE_UP_BASE;
      tcce_pkg::tcce_run_mode_t run_mode;
      tcce_pkg::tcce_edge_t edge_sel;
      logic [1:0] edge_raw;

      // R15: lower half fields at 11, 10, 8, 7-6
      assign run_mode = tcce_pkg::tcce_run_mode_t'(
        timer_control[BASE+`TCCE_F_MODE +: 2]);
      // R13: lower edge at 13-12; upper edge lives in config
      assign edge_raw = (g == 0) ?
        timer_control[BASE+`TCCE_F_EDGE +: 2] :
        timer_config[`TCCE_CFG_EDGE +: 2];
      assign edge_sel = tcce_pkg::tcce_edge_t'(edge_raw);

      // R16: 32-bit count, period and reload per half
      tcce_half #(
        .WIDTH(WIDTH)
      ) u_half (
        .pclk(pclk),
        .presetn(presetn),
        .run_mode(run_mode),
        .count_source_select(timer_control[BASE+`TCCE_F_SRC]),
        .read_clears_count(timer_control[BASE+`TCCE_F_RDCLR]),
        .capture_enable(timer_control[BASE+`TCCE_F_CAPEN]),
        .capture_edge_select(edge_sel),
        .unchained(unchained),
        .in_now(in_sync[g]),
        .in_prev(in_prev[g]),
        .count_read(acc_rd & sel_cnt[g]),
        .wr_count(acc_wr & sel_cnt[g]),
        .wr_period(acc_wr & sel_prd[g]),
        .wr_reload(acc_wr & sel_rel[g]),
        .wdata(pwdata[WIDTH-1:0]),
        .count_value(cnt[g]),
        .period_value(prd[g]),
        .period_reload_value(rel[g]),
        .period_event(per_evt[g]),
        .capture_event(cap_evt[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------
  logic [31:0] next_control;
  logic [31:0] next_config;

  // R14: reserved bits never stored, read as zero
  // R17: masked write drops reserved bits
  assign next_control = (acc_wr & sel_ctrl) ?
                        (pwdata & `TCCE_CTRL_WMASK) : timer_control;
  assign next_config = (acc_wr & sel_cfg) ?
                       (pwdata & `TCCE_CFG_WMASK) : timer_config;

  // control state, updated only at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control <= `TCCE_CTRL_RST;
      timer_config <= `TCCE_CFG_RST;
    end else begin
      timer_control <= next_control;
      timer_config <= next_config;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [`TCCE_STAT_W-1:0] stat_set;
  logic [`TCCE_STAT_W-1:0] stat_clr;
  logic [`TCCE_STAT_W-1:0] next_status;
  logic [`TCCE_STAT_W-1:0] next_mask;

  // R04: capture sets its own bit and the shared event
  assign stat_set = {cap_evt, per_evt};
  assign stat_clr = (acc_wr & sel_stat) ?
                    pwdata[`TCCE_STAT_W-1:0] : '0;
  // write one to clear; a same-cycle event keeps its bit
  assign next_status = (irq_status & ~stat_clr) | stat_set;
  assign next_mask = (acc_wr & sel_mask) ?
                     pwdata[`TCCE_STAT_W-1:0] : irq_mask;

  // sticky status and its mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= next_status;
      irq_mask <= next_mask;
    end
  end

  // level interrupt while any unmasked bit stands
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // event outputs
  // ----------------------------------------------------------------
  logic [1:0] next_event;

  // R04: capture pulses reach event pins too
  // R07: read clears feed neither input here
  assign next_event = per_evt | cap_evt;

  // one-cycle pulse per half, registered at the same edge as the status set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_out <= 2'h0;
    end else begin
      event_out <= next_event;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [31:0] mask_word;

  assign status_word = {{(32-`TCCE_STAT_W){1'b0}}, irq_status};
  assign mask_word = {{(32-`TCCE_STAT_W){1'b0}}, irq_mask};

  // selection of the addressed word, zero when unmapped
  assign rd_mux = sel_ctrl ? timer_control :
                  sel_cnt_lo ? 32'(cnt[0]) :
                  sel_cnt_up ? 32'(cnt[1]) :
                  sel_prd_lo ? 32'(prd[0]) :
                  sel_prd_up ? 32'(prd[1]) :
                  sel_rel_lo ? 32'(rel[0]) :
                  sel_rel_up ? 32'(rel[1]) :
                  sel_cfg ? timer_config :
                  sel_stat ? status_word :
                  sel_mask ? mask_word :
                  32'h0000_0000;

  // sampled in the setup cycle so prdata is a flop; the count
  // shown is the value at setup, one cycle before the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// >>> verification/tcce_pin_model.sv
// timer input pin model: applies requested levels, each held a while
`default_nettype none
module tcce_pin_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested levels
  input wire logic [1:0] want,
  // pins toward the timer
  output logic [1:0] timer_in
);
  logic [1:0] hold;
  // shorter levels could slip past the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_in <= 2'b00;
      hold <= 2'b00;
    end else if (hold != 2'b00) begin
      hold <= hold - 2'b01;
    end else if (want != timer_in) begin
      timer_in <= want;
      hold <= 2'b10;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tcce_properties.sv
// port-level checks of the timer control block
`include "tcce_regs.svh"
`default_nettype none
module tcce_properties #(
  parameter int WIDTH = 32,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and events
  input wire logic [1:0] timer_in,
  input wire logic [1:0] event_out,
  input wire logic irq
);
  logic [31:0] ctrl_sh;
  logic [31:0] cfg_sh;
  logic [3:0] mask_sh;
  wire wr_acc = psel && penable && pwrite;
  wire up_off = ctrl_sh[23:22] == 2'b00;
  wire lo_off = ctrl_sh[7:6] == 2'b00;
  wire cap_ok = cfg_sh[0] && !cfg_sh[4] && ctrl_sh[27] && !ctrl_sh[24] && ctrl_sh[23];
  // shadow of software writes, masked as the block should store them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh <= 32'h0;
      cfg_sh <= 32'h1;
      mask_sh <= 4'h0;
    end else if (wr_acc && paddr == 8'h00) begin
      ctrl_sh <= pwdata & `TCCE_CTRL_WMASK;
    end else if (wr_acc && paddr == 8'h1c) begin
      cfg_sh <= pwdata & `TCCE_CFG_WMASK;
    end else if (wr_acc && paddr == 8'h24) begin
      mask_sh <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ctrl_rd;
    psel && penable && !pwrite && paddr == 8'h00;
  endsequence
  sequence cfg_rd;
    psel && penable && !pwrite && paddr == 8'h1c;
  endsequence
  resv_zero_a: assert property (ctrl_rd |-> (prdata & ~`TCCE_CTRL_WMASK) == 32'h0)
    else $error("reserved control bits read nonzero");
  ctrl_read_a: assert property (ctrl_rd |-> prdata == ctrl_sh)
    else $error("control readback differs");
  edge_read_a: assert property (cfg_rd |-> prdata[5:4] == cfg_sh[5:4])
    else $error("edge select readback differs");
  upper_hold_a: assert property (up_off [*4] |-> !event_out[1])
    else $error("upper event while idle");
  lower_hold_a: assert property (lo_off [*4] |-> !event_out[0])
    else $error("lower event while idle");
  capture_ev_a: assert property ($rose(timer_in[1]) && cap_ok |-> ##[1:5] event_out[1])
    else $error("capture edge gave no event");
  irq_mask_a: assert property (mask_sh == 4'h0 |-> !irq)
    else $error("interrupt while all masked");
  bad_addr_a: assert property (psel && penable && (paddr[1:0] != 2'b00 || paddr > 8'h24)
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
endmodule
bind tcce_top tcce_properties #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_in(timer_in), .event_out(event_out), .irq(irq));
`default_nettype wire

// >>> verification/timer_control_capture_enable_bench.sv
// self-checking bench of the timer control block
`default_nettype none
module timer_control_capture_enable_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] want = 2'b00;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  wire [1:0] timer_in;
  wire [1:0] event_out;
  int failures = 0;
  int compares = 0;
  int ev0 = 0;
  int ev1 = 0;
  int cyc = 0;
  int e;
  logic [31:0] seed = 32'h55c9;
  logic [31:0] q;
  logic err;
  time t0;
  always #5 pclk = ~pclk;
  tcce_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_in(timer_in), .event_out(event_out), .irq(irq));
  tcce_pin_model pins (.pclk(pclk), .presetn(presetn), .want(want), .timer_in(timer_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // code 3 is reserved, so it must stay silent
  function automatic logic [31:0] cap_exp(input int c);
    return (c == 3) ? 32'h0 : (c == 2) ? 32'h2 : 32'h1;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chkb(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task automatic pin(input logic [1:0] w);
    want <= w;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wait_ev(input int i);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (event_out[i] !== 1'b1 && n < 100);
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // event tallies and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ev0 <= ev0 + int'(event_out[0] === 1'b1);
    ev1 <= ev1 + int'(event_out[1] === 1'b1);
    if (cyc == 10000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h1c);
    chk(q, 32'h1);
    rd(8'h10);
    chk(q, 32'hffff_ffff);
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h00, seed);
      rd(8'h00);
      chk(q, seed & 32'h0dc0_3dc0);
    end
    wr(8'h00, 32'h0);
    wr(8'h28, seed);
    chkb(err, 1'b1);
    rd(8'h02);
    chkb(err, 1'b1);
    $display("control done");
    seed = lfsr(seed);
    wr(8'h08, seed);
    repeat (10) @(posedge pclk);
    rd(8'h08);
    chk(q, seed);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h0080_0000);
    wait_ev(1);
    t0 = $time;
    wait_ev(1);
    chk(32'($time - t0), 32'd40);
    wr(8'h18, 32'h6);
    wr(8'h00, 32'h00c0_0000);
    wait_ev(1);
    wait_ev(1);
    t0 = $time;
    wait_ev(1);
    chk(32'($time - t0), 32'd70);
    rd(8'h10);
    chk(q, 32'h6);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h5);
    wr(8'h00, 32'h0040_0000);
    wait_ev(1);
    // let the tally take in the pulse just seen before the baseline
    @(posedge pclk);
    e = ev1;
    repeat (20) @(posedge pclk);
    rd(8'h08);
    chk(q, 32'h5);
    chk(32'(ev1 - e), 32'h0);
    $display("modes done");
    wr(8'h00, 32'h0400_0000);
    wr(8'h20, 32'hf);
    wr(8'h08, 32'h9);
    rd(8'h08);
    chk(q, 32'h9);
    rd(8'h08);
    chk(q, 32'h0);
    rd(8'h20);
    chk(q, 32'h0);
    wr(8'h1c, 32'h0);
    wr(8'h08, 32'h9);
    rd(8'h08);
    rd(8'h08);
    chk(q, 32'h9);
    $display("read clear done");
    wr(8'h10, 32'hffff_ffff);
    wr(8'h00, 32'h0880_0000);
    for (int c = 0; c < 4; c++) begin
      wr(8'h1c, 32'(1 + 16 * c));
      e = ev1;
      pin(2'b10);
      pin(2'b00);
      chk(32'(ev1 - e), cap_exp(c));
    end
    wr(8'h1c, 32'h1);
    pin(2'b10);
    rd(8'h08);
    chkb(q < 32'd20, 1'b1);
    pin(2'b00);
    wr(8'h24, 32'h8);
    @(posedge pclk);
    chkb(irq, 1'b1);
    wr(8'h20, 32'h8);
    @(posedge pclk);
    chkb(irq, 1'b0);
    wr(8'h00, 32'h0840_0000);
    e = ev1;
    pin(2'b10);
    pin(2'b00);
    chk(32'(ev1 - e), 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0180_0000);
    repeat (3) begin
      pin(2'b10);
      pin(2'b00);
    end
    rd(8'h08);
    chk(q, 32'h3);
    wr(8'h00, 32'h0000_1880);
    e = ev0;
    pin(2'b01);
    chk(32'(ev0 - e), 32'h0);
    pin(2'b00);
    chk(32'(ev0 - e), 32'h1);
    $display("capture done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
